// file: rtl/srl_top.sv
// Serial ticket printer, host reply and data-logging controller.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [R1] Up to 32 units share one multidrop link; address is five bits.
// [R2] On multidrop, answer traffic only after our own address byte arrives.
// [R3] The master sends a unit address before talking to that unit.
// [R4] Printer mode prints a ticket on reset key and on each log time.
// [R5] A key ticket is printed from the totals before they are cleared.
// [R6] No new character starts while CTS shows printer buffer full.
// [R7] Host commands are ASCII ending in carriage return.
// [R8] Every message ends with carriage return then line feed. In Xon/Xoff operation the code sends Xon after the line feed.
// [R9] An Xoff as first command character switches on Xon/Xoff operation.
// [R10] In Xon/Xoff operation messages start with Xoff and end with Xon.
// [R11] Xon/Xoff operation only on the point-to-point interface.
// [R12] Full duplex echoes each command character; half duplex does not. The code does not echo an Xoff taken as first character.
// [R13] Logging every 1, 10 or 30 minutes on matching clock marks.
// [R14] Logging every 1, 6, 12 or 24 hours at the matching hours.
// [R15] Totals clear manually, at each print start, or at midnight print.
// [R16] A disabled front reset key is ignored even in manual clear mode.
// [R17] Real-time clock in 24 hour form; date printed day or month first.
// [R18] Baud rate, parity and word length are set by configuration.
// [R19] Protocol selects a printer driver or the host command protocol.
// [R20] A disabled front reset key has no effect in normal operation.
// [R21] Frames: start bit, data LSB first, optional parity, stop bits.
module srl_top
  import srl_pkg::*;
#(
  parameter int unsigned TICK_CYC = CLK_HZ * TICK_S
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Configuration.
  input wire srl_cfg_s cfg,
  input wire srl_frame_s frame,
  // Clock setting.
  input wire srl_time_s time_set,
  input wire logic time_set_stb,
  // Front panel and totaliser.
  input wire logic reset_key,
  input wire logic [TOT_W-1:0] total_in,
  output logic total_clr,
  // Serial pins.
  input wire logic rxd,
  output logic txd,
  input wire logic cts_full,
  // Commands out.
  output logic [7:0] cmd_data,
  output logic cmd_valid,
  output logic cmd_end,
  // Replies in.
  input wire logic [7:0] reply_data,
  input wire logic reply_valid,
  input wire logic reply_last,
  output logic reply_ready,
  // Status.
  output logic selected,
  output logic xon_active,
  output logic msg_busy
);
  srl_msg_e st_q;
  logic [TICK_W-1:0] tick_cnt_q;
  logic [5:0] sec_q, min_q;
  logic [4:0] hour_q, day_q;
  logic [3:0] mon_q;
  logic [6:0] year_q;
  logic min_edge_q, log_due, tick, on_hour, midnight;
  logic cts_m_q, cts_q, key_m_q, key_s_q, key_p_q, key_evt;
  logic key_pend_q, log_pend_q, tkt_go, rep_go, host, p2p;
  logic src_tkt_q, msg_xon_q, clr_end_q, seq_done, clr_now;
  logic [4:0] tkt_idx_q;
  logic [TOT_W-1:0] tot_snap_q;
  logic [7:0] cur_char, tkt_char, body_q, echo_q, rx_byte;
  logic have_char, send, body_vld_q, body_last_q, echo_vld_q;
  logic rx_vld, host_rx, xoff_first, echo_evt, first_q;
  logic sel_q, xon_q, total_clr_q, cmd_valid_q, cmd_end_q;
  logic reply_ready_q, msg_busy_q, txd_q, tx_idle;
  logic [7:0] cmd_data_q;
  logic [11:0] tx_sh_q;
  logic [3:0] tx_cnt_q, nib;
  logic [15:0] tx_div_q;
  logic [6:0] fld_a, fld_b;

  // Days in the month, with every fourth year a leap year.
  function automatic logic [4:0] month_days(logic [3:0] m, logic [6:0] y);
    if (m == MON_FEB) begin
      return (y[1:0] == 2'h0) ? DAYS_LEAP : DAYS_FEB;
    end
    if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hB) begin
      return DAYS_SHORT;
    end
    return DAYS_LONG;
  endfunction

  // ASCII digit for a nibble, decimal or hex.
  function automatic logic [7:0] asc(logic [3:0] d);
    return (d < 4'hA) ? CH_ZERO + {4'h0, d} : CH_HEXA + {4'h0, d};
  endfunction

  // Data, parity and stop bits after the start bit, idle-padded.
  function automatic logic [11:0] frame_rest(logic [7:0] d, srl_frame_s f);
    logic [11:0] r;
    r = '1;
    if (f.seven) begin
      r[6:0] = d[6:0];
      r[7] = (f.parity == PAR_NONE) | par_bit(d, f);
    end else begin
      r[7:0] = d;
      r[8] = (f.parity == PAR_NONE) | par_bit(d, f);
    end
    return r;
  endfunction

  srl_rx u_rx (
    .clk(clk),
    .rst_b(rst_b),
    .rxd(rxd),
    .frame(frame),
    .rx_data(rx_byte),
    .rx_valid(rx_vld),
    .rx_perr()
  );

  // Mode decode and outputs straight from flops.
  assign host = (cfg.proto == PR_HOST); // [R19]
  assign p2p = (cfg.iface == IF_RS232);
  assign txd = txd_q;
  assign total_clr = total_clr_q;
  assign cmd_data = cmd_data_q;
  assign cmd_valid = cmd_valid_q;
  assign cmd_end = cmd_end_q;
  assign reply_ready = reply_ready_q;
  assign selected = sel_q;
  assign xon_active = xon_q;
  assign msg_busy = msg_busy_q;

  // Synchronisers for the key and CTS pins.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cts_m_q <= 1'b0;
      cts_q <= 1'b0;
      key_m_q <= 1'b0;
      key_s_q <= 1'b0;
      key_p_q <= 1'b0;
    end else begin
      cts_m_q <= cts_full;
      cts_q <= cts_m_q;
      key_m_q <= reset_key;
      key_s_q <= key_m_q;
      key_p_q <= key_s_q;
    end
  end
  assign key_evt = key_s_q && !key_p_q && !cfg.front_reset_dis; // [R16] [R20]

  // One-second tick for the clock.
  assign tick = (tick_cnt_q == TICK_W'(TICK_CYC - 1));
  always_ff @(posedge clk) begin
    if (!rst_b || tick || time_set_stb) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  // Calendar clock in 24 hour form.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sec_q <= '0;
      min_q <= '0;
      hour_q <= '0;
      day_q <= DAY_FIRST;
      mon_q <= MON_FIRST;
      year_q <= '0;
    end else if (time_set_stb) begin
      sec_q <= '0;
      min_q <= time_set.min;
      hour_q <= time_set.hour;
      day_q <= time_set.day;
      mon_q <= time_set.mon;
      year_q <= time_set.year;
    end else if (tick) begin
      sec_q <= (sec_q == SEC_LAST) ? '0 : sec_q + 6'h01;
      if (sec_q == SEC_LAST) begin
        min_q <= (min_q == MIN_LAST) ? '0 : min_q + 6'h01;
        if (min_q == MIN_LAST) begin
          hour_q <= (hour_q == HOUR_LAST) ? '0 : hour_q + 5'h01; // [R17]
          if (hour_q == HOUR_LAST) begin
            if (day_q != month_days(mon_q, year_q)) begin
              day_q <= day_q + 5'h01;
            end else begin
              day_q <= DAY_FIRST;
              mon_q <= (mon_q == MON_LAST) ? MON_FIRST : mon_q + 4'h1;
              if (mon_q == MON_LAST) begin
                year_q <= (year_q == YEAR_LAST) ? '0 : year_q + 7'h01;
              end
            end
          end
        end
      end
    end
  end

  // Minute boundary, after the rollover.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      min_edge_q <= 1'b0;
    end else begin
      min_edge_q <= tick && (sec_q == SEC_LAST) && !time_set_stb;
    end
  end

  // Logging schedule aligned to clock marks; hour zero is midnight.
  assign on_hour = (min_q == '0);
  assign midnight = on_hour && (hour_q == '0);
  always_comb begin
    log_due = 1'b0;
    unique case (cfg.log_sel)
      LOG_OFF: log_due = 1'b0;
      LOG_1M: log_due = 1'b1; // [R13]
      LOG_10M: log_due = (({1'b0, min_q} % DEC_TEN) == '0); // [R13]
      LOG_30M: log_due = on_hour || (min_q == MIN_HALF); // [R13]
      LOG_1H: log_due = on_hour; // [R14]
      LOG_6H: log_due = on_hour && ((hour_q % HOUR_6) == '0); // [R14]
      LOG_12H: log_due = on_hour && (hour_q % HOUR_NOON == '0); // [R14]
      LOG_24H: log_due = midnight; // [R14]
    endcase
    log_due = log_due && min_edge_q;
  end

  // Message starts: tickets first, replies only when addressed.
  assign tkt_go = (st_q == MSG_IDLE) && !echo_vld_q
    && (key_pend_q || log_pend_q);
  assign rep_go = (st_q == MSG_IDLE) && !echo_vld_q && !key_pend_q
    && !log_pend_q && host && sel_q && reply_valid; // [R2]

  // Pending ticket requests; a new event wins over its own take.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      key_pend_q <= 1'b0;
      log_pend_q <= 1'b0;
    end else begin
      if (tkt_go && key_pend_q) begin
        key_pend_q <= 1'b0;
      end
      if (tkt_go && !key_pend_q) begin
        log_pend_q <= 1'b0;
      end
      if (key_evt && !host) begin
        key_pend_q <= 1'b1; // [R4]
      end
      if (log_due) begin
        log_pend_q <= 1'b1; // [R4]
      end
    end
  end

  // Ticket text: date, time and total in hex.
  assign fld_a = cfg.date_us ? {3'h0, mon_q} : {2'h0, day_q}; // [R17]
  assign fld_b = cfg.date_us ? {2'h0, day_q} : {3'h0, mon_q};
  assign nib = tot_snap_q[4 * (TKT_LAST - tkt_idx_q) +: 4];
  always_comb begin
    tkt_char = CH_SPACE;
    case (tkt_idx_q)
      5'h00: tkt_char = asc(4'(fld_a / DEC_TEN));
      5'h01: tkt_char = asc(4'(fld_a % DEC_TEN));
      5'h02: tkt_char = CH_SLASH;
      5'h03: tkt_char = asc(4'(fld_b / DEC_TEN));
      5'h04: tkt_char = asc(4'(fld_b % DEC_TEN));
      5'h05: tkt_char = CH_SLASH;
      5'h06: tkt_char = asc(4'(year_q / DEC_TEN));
      5'h07: tkt_char = asc(4'(year_q % DEC_TEN));
      5'h09: tkt_char = asc(4'({2'h0, hour_q} / DEC_TEN));
      5'h0A: tkt_char = asc(4'({2'h0, hour_q} % DEC_TEN));
      5'h0B: tkt_char = CH_COLON;
      5'h0C: tkt_char = asc(4'({1'b0, min_q} / DEC_TEN));
      5'h0D: tkt_char = asc(4'({1'b0, min_q} % DEC_TEN));
      default: tkt_char = (tkt_idx_q >= TKT_HEX) ? asc(nib) : CH_SPACE;
    endcase
  end

  // Character offered by the sequencer in each state.
  always_comb begin
    cur_char = echo_q;
    have_char = 1'b0;
    unique case (st_q)
      MSG_IDLE: have_char = echo_vld_q;
      MSG_PRE: begin
        cur_char = CH_XOFF; // [R10]
        have_char = 1'b1;
      end
      MSG_BODY: begin
        cur_char = src_tkt_q ? tkt_char : body_q;
        have_char = src_tkt_q || body_vld_q;
      end
      MSG_CR: begin
        cur_char = CH_CR; // [R8]
        have_char = 1'b1;
      end
      MSG_LF: begin
        cur_char = CH_LF; // [R8]
        have_char = 1'b1;
      end
      MSG_POST: begin
        cur_char = CH_XON; // [R10]
        have_char = 1'b1;
      end
    endcase
  end
  assign send = have_char && tx_idle && !cts_q; // [R6]
  assign seq_done = send && ((st_q == MSG_LF && !msg_xon_q)
    || st_q == MSG_POST);

  // Message sequencer.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_q <= MSG_IDLE;
      src_tkt_q <= 1'b0;
      msg_xon_q <= 1'b0;
      clr_end_q <= 1'b0;
      tkt_idx_q <= '0;
      tot_snap_q <= '0;
    end else begin
      unique case (st_q)
        MSG_IDLE: begin
          if (tkt_go || rep_go) begin
            st_q <= xon_q ? MSG_PRE : MSG_BODY; // [R10]
            msg_xon_q <= xon_q;
            src_tkt_q <= tkt_go;
            clr_end_q <= tkt_go && key_pend_q; // [R5]
            tkt_idx_q <= '0;
            tot_snap_q <= total_in; // [R5]
          end
        end
        MSG_PRE: if (send) st_q <= MSG_BODY;
        MSG_BODY: begin
          if (send && !src_tkt_q && body_last_q) begin
            st_q <= MSG_CR;
          end else if (send && src_tkt_q) begin
            tkt_idx_q <= tkt_idx_q + 5'h01;
            if (tkt_idx_q == TKT_LAST) st_q <= MSG_CR;
          end
        end
        MSG_CR: if (send) st_q <= MSG_LF;
        MSG_LF: if (send) st_q <= msg_xon_q ? MSG_POST : MSG_IDLE;
        MSG_POST: if (send) st_q <= MSG_IDLE;
      endcase
    end
  end

  // Total clear policy.
  assign clr_now = (seq_done && clr_end_q) // [R5]
    || (tkt_go && !key_pend_q && (cfg.clr_sel == CLR_AUTO // [R15]
    || (cfg.clr_sel == CLR_MIDNIGHT && midnight))) // [R15]
    || (key_evt && host); // [R15]
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      total_clr_q <= 1'b0;
      msg_busy_q <= 1'b0;
    end else begin
      total_clr_q <= clr_now;
      msg_busy_q <= (st_q != MSG_IDLE);
    end
  end

  // Reply byte stage with its ready handshake.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      body_vld_q <= 1'b0;
      body_last_q <= 1'b0;
      body_q <= '0;
      reply_ready_q <= 1'b0;
    end else begin
      if (send && st_q == MSG_BODY && !src_tkt_q) begin
        body_vld_q <= 1'b0;
      end
      if (reply_valid && reply_ready_q) begin
        body_vld_q <= 1'b1;
        body_q <= reply_data;
        body_last_q <= reply_last;
      end
      reply_ready_q <= (st_q == MSG_BODY) && !src_tkt_q && !body_vld_q
        && !(reply_valid && reply_ready_q);
    end
  end

  // Addressing: always selected point to point, else by address byte.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel_q <= 1'b0;
    end else if (p2p) begin
      sel_q <= 1'b1;
    end else if (rx_vld && !sel_q
        && rx_byte == {ADDR_TAG, cfg.unit_addr}) begin
      sel_q <= 1'b1; // [R1] [R2] [R3]
    end else if (seq_done && !src_tkt_q) begin
      sel_q <= 1'b0;
    end
  end

  // Command reception, Xoff detection and echo request.
  assign host_rx = rx_vld && sel_q && host;
  assign xoff_first = first_q && (rx_byte == CH_XOFF); // [R9]
  assign echo_evt = host_rx && cfg.full_duplex && !xoff_first; // [R12]
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      first_q <= 1'b1;
      xon_q <= 1'b0;
      cmd_data_q <= '0;
      cmd_valid_q <= 1'b0;
      cmd_end_q <= 1'b0;
    end else begin
      cmd_valid_q <= host_rx && !xoff_first;
      cmd_end_q <= host_rx && !xoff_first && rx_byte == CH_CR; // [R7]
      if (!p2p) begin
        xon_q <= 1'b0; // [R11]
      end else if (host_rx && first_q) begin
        xon_q <= xoff_first; // [R9]
      end
      if (host_rx) begin
        first_q <= xoff_first ? 1'b0 : (rx_byte == CH_CR); // [R7]
        cmd_data_q <= rx_byte;
      end
    end
  end

  // Pending echo; a new character wins over the one being sent.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      echo_vld_q <= 1'b0;
      echo_q <= '0;
    end else begin
      if (send && st_q == MSG_IDLE) begin
        echo_vld_q <= 1'b0;
      end
      if (echo_evt) begin
        echo_vld_q <= 1'b1; // [R12]
        echo_q <= rx_byte;
      end
    end
  end

  // Transmit shifter: start, data, parity and stop bits.
  assign tx_idle = (tx_cnt_q == '0);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txd_q <= 1'b1;
      tx_sh_q <= '1;
      tx_cnt_q <= '0;
      tx_div_q <= '0;
    end else if (send) begin
      txd_q <= 1'b0; // [R21]
      tx_sh_q <= frame_rest(cur_char, frame); // [R18] [R21]
      tx_cnt_q <= frame_len(frame);
      tx_div_q <= frame.baud_div - 16'h0001; // [R18]
    end else if (!tx_idle) begin
      if (tx_div_q != '0) begin
        tx_div_q <= tx_div_q - 16'h0001;
      end else begin
        tx_div_q <= frame.baud_div - 16'h0001;
        txd_q <= tx_sh_q[0];
        tx_sh_q <= {1'b1, tx_sh_q[11:1]};
        tx_cnt_q <= tx_cnt_q - 4'h1;
      end
    end
  end
endmodule // srl_top
`default_nettype wire

// file: rtl/srl_pkg.sv
// Shared constants, types and helpers for the serial report logger.
package srl_pkg;
  // Instrument clock and real-time clock tick.
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_W = 26;
  // Control characters and ticket punctuation.
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_XON = 8'h11;
  localparam logic [7:0] CH_XOFF = 8'h13;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_HEXA = 8'h37;
  localparam logic [7:0] CH_SLASH = 8'h2F;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SPACE = 8'h20;
  // Multidrop addressing: 32 units; an address byte is the tag and the unit.
  localparam int unsigned ADDR_W = 5;
  localparam logic [2:0] ADDR_TAG = 3'h4;
  localparam int unsigned TOT_W = 32;
  // Calendar limits and logging marks.
  localparam logic [5:0] SEC_LAST = 6'h3B;
  localparam logic [5:0] MIN_LAST = 6'h3B;
  localparam logic [5:0] MIN_HALF = 6'h1E;
  localparam logic [4:0] HOUR_LAST = 5'h17;
  localparam logic [4:0] HOUR_6 = 5'h06;
  localparam logic [4:0] HOUR_NOON = 5'h0C;
  localparam logic [4:0] DAY_FIRST = 5'h01;
  localparam logic [4:0] DAYS_LONG = 5'h1F;
  localparam logic [4:0] DAYS_SHORT = 5'h1E;
  localparam logic [4:0] DAYS_FEB = 5'h1C;
  localparam logic [4:0] DAYS_LEAP = 5'h1D;
  localparam logic [3:0] MON_FIRST = 4'h1;
  localparam logic [3:0] MON_FEB = 4'h2;
  localparam logic [3:0] MON_LAST = 4'hC;
  localparam logic [6:0] YEAR_LAST = 7'h63;
  localparam logic [6:0] DEC_TEN = 7'h0A;
  // Ticket layout: last character index and first hex digit index.
  localparam logic [4:0] TKT_LAST = 5'h16;
  localparam logic [4:0] TKT_HEX = 5'h0F;
  // Frame length with eight data bits, no parity, one stop; parity slot.
  localparam logic [3:0] LEN_BASE = 4'hA;
  localparam logic [3:0] PAR_POS8 = 4'h9;
  typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} srl_par_e;
  typedef enum logic [1:0] {IF_RS232, IF_RS422, IF_RS485} srl_if_e;
  typedef enum logic [1:0] {PR_STD, PR_SLIP, PR_HOST} srl_proto_e;
  typedef enum logic [2:0] {LOG_OFF, LOG_1M, LOG_10M, LOG_30M,
    LOG_1H, LOG_6H, LOG_12H, LOG_24H} srl_log_e;
  typedef enum logic [1:0] {CLR_MANUAL, CLR_AUTO, CLR_MIDNIGHT} srl_clr_e;
  typedef enum {MSG_IDLE, MSG_PRE, MSG_BODY, MSG_CR, MSG_LF,
    MSG_POST} srl_msg_e;
  typedef struct packed {
    logic [15:0] baud_div;
    logic seven;
    srl_par_e parity;
    logic two_stop;
  } srl_frame_s;
  typedef struct packed {
    srl_proto_e proto;
    srl_if_e iface;
    srl_log_e log_sel;
    srl_clr_e clr_sel;
    logic full_duplex;
    logic front_reset_dis;
    logic date_us;
    logic [ADDR_W-1:0] unit_addr;
  } srl_cfg_s;
  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] min;
    logic [4:0] day;
    logic [3:0] mon;
    logic [6:0] year;
  } srl_time_s;
  // Parity bit for a character under the given framing.
  function automatic logic par_bit(logic [7:0] d, srl_frame_s f);
    logic p;
    p = f.seven ? ^d[6:0] : ^d;
    return (f.parity == PAR_ODD) ? ~p : p;
  endfunction
  // Bit periods in one frame, start bit included.
  function automatic logic [3:0] frame_len(srl_frame_s f);
    return LEN_BASE - {3'h0, f.seven} + {3'h0, f.parity != PAR_NONE}
      + {3'h0, f.two_stop};
  endfunction
endpackage

// file: rtl/srl_rx.sv
// Asynchronous serial receiver with mid-bit sampling and parity check.
`timescale 1ns/1ps
`default_nettype none
module srl_rx
  import srl_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Line and framing.
  input wire logic rxd,
  input wire srl_frame_s frame,
  // Received character.
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_perr
);
  logic rx_m_q, rx_s_q, rx_p_q, busy_q, done_q, valid_q, perr_q;
  logic [15:0] div_q;
  logic [3:0] bit_q;
  logic [11:0] sh_q;
  logic [7:0] data_q, word;
  logic [3:0] pidx;
  logic ok;
  // Word and parity slot from the sampled bits.
  assign word = frame.seven ? {1'b0, sh_q[7:1]} : sh_q[8:1];
  assign pidx = PAR_POS8 - {3'h0, frame.seven};
  assign ok = (frame.parity == PAR_NONE) || (sh_q[pidx] == par_bit(word, frame));
  assign rx_data = data_q;
  assign rx_valid = valid_q;
  assign rx_perr = perr_q;
  // Two-flop synchroniser and a copy for start detection.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
      rx_p_q <= 1'b1;
    end else begin
      rx_m_q <= rxd;
      rx_s_q <= rx_m_q;
      rx_p_q <= rx_s_q;
    end
  end
  // Bit timing: half a bit to the start centre, then one bit per sample.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      div_q <= '0;
      bit_q <= '0;
      sh_q <= '1;
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        if (rx_p_q && !rx_s_q) begin
          busy_q <= 1'b1;
          div_q <= {1'b0, frame.baud_div[15:1]};
          bit_q <= '0;
        end
      end else if (div_q != '0) begin
        div_q <= div_q - 16'h0001;
      end else begin
        div_q <= frame.baud_div - 16'h0001;
        if (bit_q == '0 && rx_s_q) begin
          busy_q <= 1'b0; // A glitch, not a start bit.
        end else begin
          sh_q[bit_q] <= rx_s_q; // [R21]
          bit_q <= bit_q + 4'h1;
          if (bit_q == frame_len(frame) - 4'h1) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
      end
    end
  end
  // Deliver good characters; flag parity failures.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      data_q <= '0;
      valid_q <= 1'b0;
      perr_q <= 1'b0;
    end else begin
      valid_q <= done_q && ok; // [R18]
      perr_q <= done_q && !ok;
      if (done_q) begin
        data_q <= word;
      end
    end
  end
endmodule // srl_rx
`default_nettype wire

// file: verif/srl_top_checker.sv
// Port checker for the serial report logger.
`timescale 1ns/1ps
`default_nettype none
module srl_top_checker
  import srl_pkg::*;
#(parameter int unsigned TICK_CYC = 20) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Watched ports.
  input wire srl_cfg_s cfg,
  input wire logic txd,
  input wire logic total_clr,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_valid,
  input wire logic cmd_end,
  input wire logic selected,
  input wire logic xon_active,
  input wire logic msg_busy,
  input wire logic reply_ready
);
  // All properties share one clock and reset.
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_rst; $rose(rst_b) |-> txd && !msg_busy && !reply_ready
    && !selected && !xon_active; endproperty
  property p_hold; $changed(txd) |=> $stable(txd); endproperty
  property p_clr; total_clr |=> !total_clr; endproperty
  property p_end; cmd_end |-> cmd_valid && cmd_data == CH_CR; endproperty
  property p_xon; $rose(xon_active) |-> cfg.iface == IF_RS232; endproperty
  property p_sel; (cfg.iface == IF_RS232) [*2] |-> selected; endproperty
  property p_cmd; cmd_valid |-> cfg.proto == PR_HOST; endproperty
  property p_dis; (cfg.front_reset_dis && cfg.clr_sel == CLR_MANUAL) [*8]
    |-> !total_clr; endproperty
  a_rst: assert property (p_rst) else $error("bad idle after reset");
  a_hold: assert property (p_hold) else $error("bit too short");
  a_clr: assert property (p_clr) else $error("clear too long");
  a_end: assert property (p_end) else $error("end without CR");
  a_xon: assert property (p_xon) else $error("xon off rs232");
  a_sel: assert property (p_sel) else $error("not selected");
  a_cmd: assert property (p_cmd) else $error("command in printer");
  a_dis: assert property (p_dis) else $error("key not ignored");
  c_clr: cover property (total_clr);
  c_end: cover property (cmd_end);
  c_xon: cover property ($rose(xon_active));
endmodule // srl_top_checker
bind srl_top srl_top_checker #(.TICK_CYC(TICK_CYC)) u_chk (.clk, .rst_b,
  .cfg, .txd, .total_clr, .cmd_data, .cmd_valid, .cmd_end, .selected,
  .xon_active, .msg_busy, .reply_ready);
`default_nettype wire

// file: verif/srl_host.sv
// Host and printer model that decodes txd and drives rxd.
`timescale 1ns/1ps
`default_nettype none
module srl_host #(parameter int BD = 4) (
  // Clock.
  input wire logic clk,
  // Serial pins.
  input wire logic txd,
  output logic rxd,
  // Decoded byte.
  output logic [7:0] got,
  output logic got_stb
);
  // Line idles high.
  initial rxd = 1'b1;
  initial got_stb = 1'b0;
  // Samples each bit mid-cell; strobes only on a good stop bit.
  always begin
    @(negedge txd);
    repeat (BD / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BD) @(posedge clk);
      got[i] <= txd;
    end
    repeat (BD) @(posedge clk);
    got_stb <= txd;
    @(posedge clk);
    got_stb <= 1'b0;
  end
  // Sends one frame at the device's bit time.
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BD) @(posedge clk);
    end
  endtask
endmodule // srl_host
`default_nettype wire

// file: verif/serial_report_logger_test.sv
// Self-checking bench for the serial report logger.
`timescale 1ns/1ps
`default_nettype none
module serial_report_logger_test
  import srl_pkg::*; ;
  logic clk = 0, rst_b = 0, time_set_stb = 0, reset_key = 0, cts_full = 0;
  logic reply_valid = 0, reply_last = 0, rxd, txd, total_clr, cmd_valid;
  logic cmd_end, reply_ready, got_stb, selected, xon_active, msg_busy;
  logic [7:0] reply_data = 0, cmd_data, got, c;
  logic [TOT_W-1:0] total_in = 0;
  srl_cfg_s cfg = '{PR_HOST, IF_RS232, LOG_OFF, CLR_MANUAL, 0, 0, 0, 0};
  srl_frame_s frame = '{16'h0004, 1'b0, PAR_NONE, 1'b0};
  srl_time_s time_set = '{5'h0C, 6'h22, 5'h05, 4'h3, 7'h07};
  logic [7:0] txq[$], cq[$];
  string tk = "05/03/07 12:34 ";
  int n_mismatch = 0, n_checks = 0, nclr = 0;
  // Design and far-side model.
  srl_top #(.TICK_CYC(20)) DUT (.clk, .rst_b, .cfg, .frame, .time_set,
    .time_set_stb, .reset_key, .total_in, .total_clr, .rxd, .txd, .cts_full,
    .cmd_data, .cmd_valid, .cmd_end, .reply_data, .reply_valid, .reply_last,
    .reply_ready, .selected, .xon_active, .msg_busy);
  srl_host #(.BD(4)) H (.clk, .txd, .rxd, .got, .got_stb);
  // Clock at 40 MHz.
  always #12.5 clk = ~clk;
  // Compares one value with its expectation.
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // Pops the oldest note for each byte; a clear checks that at most one note is left.
  always @(posedge clk) begin
    if (got_stb === 1'b1) chk(got, txq.size() ? txq.pop_front() : 8'hXX);
    if (cmd_valid === 1'b1) chk(cmd_data, cq.size() ? cq.pop_front() : 8'hXX);
    if (total_clr === 1'b1) begin
      nclr++;
      chk(8'(txq.size() > 1), 8'h00);
    end
  end
  // Waits for every expectation.
  task automatic drain;
    repeat (3000) if (txq.size() + cq.size() > 0) @(posedge clk);
    chk(8'(txq.size() + cq.size()), 8'h00);
  endtask
  // Offers a reply byte; notes the wrapped message.
  task automatic rep(input logic [7:0] b, input logic x);
    if (x) txq.push_back(CH_XOFF);
    txq.push_back(b);
    txq.push_back(CH_CR);
    txq.push_back(CH_LF);
    if (x) txq.push_back(CH_XON);
    reply_data <= b;
    reply_last <= 1'b1;
    reply_valid <= 1'b1;
    do @(posedge clk); while (reply_ready !== 1'b1);
    reply_valid <= 1'b0;
  endtask
  // Sends a command byte and notes its output and echo.
  task automatic cmd(input logic [7:0] b);
    if (b != CH_XOFF) cq.push_back(b);
    if (cfg.full_duplex && b != CH_XOFF) txq.push_back(b);
    H.send(b);
  endtask
  // Presses the front reset key.
  task automatic key;
    reset_key <= 1'b1;
    repeat (4) @(posedge clk);
    reset_key <= 1'b0;
    repeat (300) @(posedge clk);
  endtask
  // Prints the counts and the verdict.
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end
  // Main sequence.
  initial begin
    void'($urandom(32'h46330007));
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    c = 8'h41 + 8'($urandom % 26);
    cmd(CH_XOFF);
    cmd(c);
    cmd(CH_CR);
    drain;
    chk({7'h0, xon_active}, 8'h01);
    rep(c + 8'h01, 1'b1);
    drain;
    cfg.full_duplex <= 1'b1;
    @(posedge clk);
    cmd(c);
    cmd(CH_CR);
    drain;
    chk({7'h0, xon_active}, 8'h00);
    cfg.iface <= IF_RS485;
    cts_full <= 1'b1;
    repeat (4) @(posedge clk);
    rep(c, 1'b0);
    repeat (200) @(posedge clk);
    chk(8'(txq.size()), 8'h03);
    cts_full <= 1'b0;
    drain;
    chk({7'h0, selected}, 8'h00);
    H.send({ADDR_TAG, 5'h00});
    cfg.proto <= PR_STD;
    cfg.front_reset_dis <= 1'b1;
    total_in <= $urandom;
    time_set_stb <= 1'b1;
    @(posedge clk);
    time_set_stb <= 1'b0;
    key;
    chk(8'(nclr), 8'h00);
    chk({7'h0, selected}, 8'h01);
    cfg.front_reset_dis <= 1'b0;
    foreach (tk[i]) txq.push_back(tk[i]);
    for (int i = 7; i >= 0; i--) begin
      c = {4'h0, total_in[i*4+:4]};
      txq.push_back(c < 8'h0A ? 8'h30 + c : 8'h37 + c);
    end
    txq.push_back(CH_CR);
    txq.push_back(CH_LF);
    key;
    drain;
    chk(8'(nclr), 8'h01);
    end_sim;
  end
endmodule // serial_report_logger_test
`default_nettype wire
